//--- design/xmr_pkg.sv
// constants for the memory-xor / round-load / buffer-xor datapath
// assumes a 16-bit data memory word and a 32-bit accumulator
package xmr_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ACC_W  = 32;
  localparam int unsigned OP_W   = 3;
  // operation codes from the instruction decoder
  localparam logic [2:0] OP_NOP       = 3'h0;
  localparam logic [2:0] OP_XOR_INTO_MEM_IMM  = 3'h1;
  localparam logic [2:0] OP_XOR_INTO_MEM_MASK = 3'h2;
  localparam logic [2:0] OP_RND_LOAD  = 3'h3;
  localparam logic [2:0] OP_CLR_PROD  = 3'h4;
  localparam logic [2:0] OP_XOR_BUF   = 3'h5;
  // round-load fills the low half with one half lsb
  localparam logic [15:0] ROUND_LOW   = 16'h8000;
  localparam logic [15:0] ZERO_WORD   = 16'h0000;
  localparam logic [31:0] ZERO_ACC    = 32'h0000_0000;
  localparam logic [31:0] ACC_RESET   = 32'h0000_0000;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  // memory read latency in cycles after the read strobe
  localparam int unsigned MEM_RD_LAT  = 1;
  typedef enum logic [1:0] {S_IDLE, S_READ, S_CALC, S_WRITE} state_t;
endpackage

//--- design/xor_if.sv
// carrier between the datapath and its xor/zero-test unit
// assumes xmr_pkg is compiled first
`timescale 1ns/1ps
`default_nettype none
interface xor_if;
  logic [xmr_pkg::DATA_W-1:0] a;
  logic [xmr_pkg::DATA_W-1:0] b;
  logic [xmr_pkg::DATA_W-1:0] y;
  logic                       zero;
  modport calc (input a, input b, output y, output zero);
  modport user (output a, output b, input y, input zero);
endinterface
`default_nettype wire

//--- design/xor_unit.sv
// combinational word xor with zero detect
// assumes operands are driven by the datapath through xor_if
`timescale 1ns/1ps
`default_nettype none
module xor_unit (
  xor_if.calc x
);
  always_comb begin
    x.y    = x.a ^ x.b;
    x.zero = ((x.a ^ x.b) == xmr_pkg::ZERO_WORD);
  end
endmodule
`default_nettype wire

//--- design/xmr_datapath.sv
// memory-xor, round-load, clear-product and buffer-xor datapath
// assumes a decoder offering one op at a time and data memory with one-cycle read latency
`timescale 1ns/1ps
`default_nettype none
// Operation
// - with an immediate, xor the immediate into the addressed memory word
// - without an immediate, xor the mask register into the addressed word
// - write the xor result back to the same memory address
// - memory-xor leaves the accumulator unchanged
// - test flag becomes 1 when the xor result is zero, else 0
// - clear-product zeroes the product register, nothing else changes
module xmr_datapath #(
  parameter int unsigned ADDR_W = 16
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_arst_n,
  input  wire logic                       i_ce,
  input  wire logic                       i_op_valid,
  input  wire logic [xmr_pkg::OP_W-1:0]   i_op,
  input  wire logic [ADDR_W-1:0]          i_addr,
  input  wire logic [xmr_pkg::DATA_W-1:0] i_imm,
  input  wire logic [xmr_pkg::DATA_W-1:0] i_mem_rdata,
  input  wire logic                       i_acc_wr,
  input  wire logic [xmr_pkg::ACC_W-1:0]  i_acc_data,
  input  wire logic                       i_accumulator_buffer_wr,
  input  wire logic [xmr_pkg::ACC_W-1:0]  i_accumulator_buffer_data,
  input  wire logic                       i_product_reg_wr,
  input  wire logic [xmr_pkg::ACC_W-1:0]  i_product_reg_data,
  input  wire logic                       i_dynamic_bit_mask_reg_wr,
  input  wire logic [xmr_pkg::DATA_W-1:0] i_dynamic_bit_mask_reg_data,
  output logic                            o_ready,
  output logic                            o_done,
  output logic                            o_mem_rd,
  output logic                            o_mem_wr,
  output logic [ADDR_W-1:0]               o_mem_addr,
  output logic [xmr_pkg::DATA_W-1:0]      o_mem_wdata,
  output logic [xmr_pkg::ACC_W-1:0]       o_acc,
  output logic [xmr_pkg::ACC_W-1:0]       o_accumulator_buffer,
  output logic [xmr_pkg::ACC_W-1:0]       o_product_reg,
  output logic [xmr_pkg::DATA_W-1:0]      o_dynamic_bit_mask_reg,
  output logic                            o_test_control_flag
);
  if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must be 1..32");
  end

  xor_if xu ();
  xor_unit u_xor (
    .x (xu.calc)
  );

  xmr_pkg::state_t                state;
  xmr_pkg::state_t                next_state;
  logic [xmr_pkg::OP_W-1:0]       op_q;
  logic [xmr_pkg::OP_W-1:0]       next_op_q;
  logic [xmr_pkg::DATA_W-1:0]     imm_q;
  logic [xmr_pkg::DATA_W-1:0]     next_imm_q;
  logic                           next_ready;
  logic                           next_done;
  logic                           next_mem_rd;
  logic                           next_mem_wr;
  logic [ADDR_W-1:0]              next_mem_addr;
  logic [xmr_pkg::DATA_W-1:0]     next_mem_wdata;
  logic [xmr_pkg::ACC_W-1:0]      next_acc;
  logic [xmr_pkg::ACC_W-1:0]      next_accumulator_buffer;
  logic [xmr_pkg::ACC_W-1:0]      next_product_reg;
  logic [xmr_pkg::DATA_W-1:0]     next_dynamic_bit_mask_reg;
  logic                           next_test_control_flag;
  logic                           accept;

  function automatic logic is_mem_op(input logic [xmr_pkg::OP_W-1:0] op);
    return (op == xmr_pkg::OP_XOR_INTO_MEM_IMM) || (op == xmr_pkg::OP_XOR_INTO_MEM_MASK)
        || (op == xmr_pkg::OP_RND_LOAD);
  endfunction

  function automatic logic is_xor_op(input logic [xmr_pkg::OP_W-1:0] op);
    return (op == xmr_pkg::OP_XOR_INTO_MEM_IMM) || (op == xmr_pkg::OP_XOR_INTO_MEM_MASK);
  endfunction

  assign accept = i_op_valid && o_ready;

  // operand select for the xor unit
  always_comb begin
    xu.a = i_mem_rdata;
    xu.b = (op_q == xmr_pkg::OP_XOR_INTO_MEM_IMM) ? imm_q
                                                   : o_dynamic_bit_mask_reg;
  end

  always_comb begin
    next_state     = state;
    next_op_q      = op_q;
    next_imm_q     = imm_q;
    next_done      = 1'b0;
    next_mem_rd    = 1'b0;
    next_mem_wr    = 1'b0;
    next_mem_addr  = o_mem_addr;
    next_mem_wdata = o_mem_wdata;
    next_acc       = o_acc;
    next_accumulator_buffer   = o_accumulator_buffer;
    next_product_reg          = o_product_reg;
    next_dynamic_bit_mask_reg = o_dynamic_bit_mask_reg;
    next_test_control_flag    = o_test_control_flag;
    unique case (state)
      xmr_pkg::S_IDLE: begin
        if (accept && is_mem_op(i_op)) begin
          next_op_q     = i_op;
          next_imm_q    = i_imm;
          next_mem_addr = i_addr;
          next_mem_rd   = 1'b1;
          next_state    = xmr_pkg::S_READ;
        end else if (accept && i_op == xmr_pkg::OP_CLR_PROD) begin
          next_product_reg = xmr_pkg::ZERO_ACC;
          next_done = 1'b1;
        end else if (accept && i_op == xmr_pkg::OP_XOR_BUF) begin
          next_acc  = o_acc ^ o_accumulator_buffer;
          next_done = 1'b1;
        end else begin
          if (accept) begin
            next_done = 1'b1;
          end
          if (i_acc_wr) begin
            next_acc = i_acc_data;
          end
          if (i_accumulator_buffer_wr) begin
            next_accumulator_buffer = i_accumulator_buffer_data;
          end
          if (i_product_reg_wr) begin
            next_product_reg = i_product_reg_data;
          end
          if (i_dynamic_bit_mask_reg_wr) begin
            next_dynamic_bit_mask_reg = i_dynamic_bit_mask_reg_data;
          end
        end
      end
      xmr_pkg::S_READ: begin
        next_state = xmr_pkg::S_CALC;
      end
      xmr_pkg::S_CALC: begin
        if (is_xor_op(op_q)) begin
          // accumulator left as is for memory-xor
          next_mem_wdata = xu.y;
          next_mem_wr    = 1'b1;   // same address still held
          next_test_control_flag = xu.zero;
          next_state     = xmr_pkg::S_WRITE;
        end else begin
          next_acc   = {i_mem_rdata, xmr_pkg::ROUND_LOW};
          next_done  = 1'b1;
          next_state = xmr_pkg::S_IDLE;
        end
      end
      xmr_pkg::S_WRITE: begin
        next_done  = 1'b1;
        next_state = xmr_pkg::S_IDLE;
      end
    endcase
    next_ready = (next_state == xmr_pkg::S_IDLE);
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state       <= xmr_pkg::S_IDLE;
      op_q        <= xmr_pkg::OP_NOP;
      imm_q       <= xmr_pkg::WORD_RESET;
      o_ready     <= 1'b1;
      o_done      <= 1'b0;
      o_mem_rd    <= 1'b0;
      o_mem_wr    <= 1'b0;
      o_mem_addr  <= '0;
      o_mem_wdata <= xmr_pkg::WORD_RESET;
      o_acc       <= xmr_pkg::ACC_RESET;
      o_accumulator_buffer   <= xmr_pkg::ACC_RESET;
      o_product_reg          <= xmr_pkg::ACC_RESET;
      o_dynamic_bit_mask_reg <= xmr_pkg::WORD_RESET;
      o_test_control_flag    <= 1'b0;
    end else if (i_ce) begin
      state       <= next_state;
      op_q        <= next_op_q;
      imm_q       <= next_imm_q;
      o_ready     <= next_ready;
      o_done      <= next_done;
      o_mem_rd    <= next_mem_rd;
      o_mem_wr    <= next_mem_wr;
      o_mem_addr  <= next_mem_addr;
      o_mem_wdata <= next_mem_wdata;
      o_acc       <= next_acc;
      o_accumulator_buffer   <= next_accumulator_buffer;
      o_product_reg          <= next_product_reg;
      o_dynamic_bit_mask_reg <= next_dynamic_bit_mask_reg;
      o_test_control_flag    <= next_test_control_flag;
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_xor_imm_data: assert property (i_ce && state == xmr_pkg::S_CALC
    && op_q == xmr_pkg::OP_XOR_INTO_MEM_IMM
    |=> o_mem_wdata == ($past(i_mem_rdata) ^ $past(imm_q)))
    else $error("immediate xor result wrong");
  a_xor_mask_data: assert property (i_ce && state == xmr_pkg::S_CALC
    && op_q == xmr_pkg::OP_XOR_INTO_MEM_MASK
    |=> o_mem_wdata == ($past(i_mem_rdata) ^ $past(o_dynamic_bit_mask_reg)))
    else $error("mask xor result wrong");
  a_wb_same_addr: assert property (i_ce && accept && is_xor_op(i_op)
    |=> o_mem_rd && o_mem_addr == $past(i_addr))
    else $error("read address not taken");
  a_wb_addr_held: assert property ($rose(o_mem_wr)
    |-> $stable(o_mem_addr) && $past(state) == xmr_pkg::S_CALC)
    else $error("write-back address moved");
  a_xor_acc_hold: assert property (i_ce && state != xmr_pkg::S_IDLE && is_xor_op(op_q)
    |=> o_acc == $past(o_acc))
    else $error("accumulator changed by memory xor");
  a_flag_on_zero: assert property (o_mem_wr
    |-> o_test_control_flag == (o_mem_wdata == xmr_pkg::ZERO_WORD))
    else $error("test flag does not match zero result");
  a_round_high: assert property (i_ce && state == xmr_pkg::S_CALC
    && op_q == xmr_pkg::OP_RND_LOAD |=> o_acc[31:16] == $past(i_mem_rdata) && o_done)
    else $error("round-load high half wrong");
  a_round_low: assert property (i_ce && state == xmr_pkg::S_CALC
    && op_q == xmr_pkg::OP_RND_LOAD |=> o_acc[15:0] == xmr_pkg::ROUND_LOW)
    else $error("round-load low half wrong");
  a_clear_prod: assert property (i_ce && accept && i_op == xmr_pkg::OP_CLR_PROD
    |=> o_product_reg == xmr_pkg::ZERO_ACC && $stable(o_acc) && $stable(o_accumulator_buffer)
    && $stable(o_dynamic_bit_mask_reg) && o_done)
    else $error("product clear wrong");
  a_buf_xor_acc: assert property (i_ce && accept && i_op == xmr_pkg::OP_XOR_BUF
    |=> o_acc == ($past(o_acc) ^ $past(o_accumulator_buffer))
    && $stable(o_accumulator_buffer))
    else $error("buffer xor wrong");

  c_xor_zero: cover property (o_mem_wr && o_test_control_flag);
  c_round_load: cover property (state == xmr_pkg::S_CALC && op_q == xmr_pkg::OP_RND_LOAD);
  c_buf_xor: cover property (accept && i_op == xmr_pkg::OP_XOR_BUF);
endmodule
`default_nettype wire

//--- tb/data_mem_model.sv
// data memory model facing the datapath: one-cycle read latency, write on strobe
// assumes single-cycle read and write strobes from the datapath
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_rdata
);
  logic [15:0] store [16];
  initial o_rdata = 16'h0000;
  always @(posedge i_clk) begin
    if (i_wr)
      store[i_addr[3:0]] <= i_wdata;
    // outside the read slot the data lines toggle, so stale data never looks valid
    if (i_rd)
      o_rdata <= store[i_addr[3:0]];
    else
      o_rdata <= ~o_rdata;
  end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the memory-xor / round-load / buffer-xor datapath
// assumes xmr_pkg and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        ce = 1'b1;
  logic        valid = 1'b0;
  logic [3:0]  wr = 4'h0;
  logic [2:0]  op = 3'h0;
  logic [15:0] addr = 16'h0000, imm = 16'h0000, mask_d = 16'h0000, rdata;
  logic [31:0] acc_d = 32'h0, abuf_d = 32'h0, prod_d = 32'h0;
  logic        ready, done, mem_rd, mem_wr, flag;
  logic        rd_seen = 1'b0, busy_seen = 1'b0;
  logic [15:0] mem_addr, wdata, mask;
  logic [31:0] acc, abuf, prod;
  int          err_total = 0;
  int          total_checks = 0;
  int          lat = 0;
  always #25 clk = ~clk;
  xmr_datapath uut (.i_clk(clk), .i_arst_n(arst_n), .i_ce(ce), .i_op_valid(valid),
    .i_op(op), .i_addr(addr), .i_imm(imm), .i_mem_rdata(rdata), .i_acc_wr(wr[3]),
    .i_acc_data(acc_d), .i_accumulator_buffer_wr(wr[2]), .i_accumulator_buffer_data(abuf_d),
    .i_product_reg_wr(wr[1]), .i_product_reg_data(prod_d), .i_dynamic_bit_mask_reg_wr(wr[0]),
    .i_dynamic_bit_mask_reg_data(mask_d), .o_ready(ready), .o_done(done), .o_mem_rd(mem_rd),
    .o_mem_wr(mem_wr), .o_mem_addr(mem_addr), .o_mem_wdata(wdata), .o_acc(acc),
    .o_accumulator_buffer(abuf), .o_product_reg(prod), .o_dynamic_bit_mask_reg(mask),
    .o_test_control_flag(flag));
  data_mem_model mem (.i_clk(clk), .i_rd(mem_rd), .i_wr(mem_wr), .i_addr(mem_addr),
    .i_wdata(wdata), .o_rdata(rdata));
  task end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task load_regs(input logic [31:0] a, input logic [31:0] b, input logic [31:0] p,
                 input logic [15:0] m);
    @(posedge clk);
    wr     <= 4'hF;
    acc_d  <= a;
    abuf_d <= b;
    prod_d <= p;
    mask_d <= m;
    @(posedge clk);
    wr <= 4'h0;
  endtask
  task run_op(input logic [2:0] code, input logic [15:0] a, input logic [15:0] k);
    int n;
    n = 0;
    rd_seen = 1'b0;
    busy_seen = 1'b0;
    @(posedge clk);
    valid <= 1'b1;
    op    <= code;
    addr  <= a;
    imm   <= k;
    @(posedge clk);
    valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
      rd_seen = rd_seen | mem_rd;
      busy_seen = busy_seen | !ready;
    end while (done !== 1'b1 && n < 10);
    lat = n;
    if (n >= 10) begin
      err_total++;
      end_sim();
    end
  endtask
  task t_xor_imm;
    mem.store[3] = 16'h00FF;
    mem.store[4] = 16'h1234;
    load_regs(32'h12345678, 32'h0, 32'h0, 16'h0);
    run_op(xmr_pkg::OP_XOR_INTO_MEM_IMM, 16'h0003, 16'h0F0F);
    `CHK("mem3", 16'h0FF0, mem.store[3])
    `CHK("wdata", 16'h0FF0, wdata)
    `CHK("mem4", 16'h1234, mem.store[4])
    `CHK("rd", 1'b1, rd_seen)
    `CHK("busy", 1'b1, busy_seen)
    `CHK("lat", 4, lat)
    `CHK("ready", 1'b1, ready)
    `CHK("flag", 1'b0, flag)
    `CHK("acc", 32'h12345678, acc)
    run_op(xmr_pkg::OP_XOR_INTO_MEM_IMM, 16'h0003, 16'h0FF0);
    `CHK("mem3z", 16'h0000, mem.store[3])
    `CHK("flagz", 1'b1, flag)
  endtask
  task t_xor_mask;
    mem.store[5] = 16'h0EF0;
    load_regs(32'hCAFE0001, 32'h0, 32'h0, 16'hFF00);
    run_op(xmr_pkg::OP_XOR_INTO_MEM_MASK, 16'h0005, 16'hFFFF);
    `CHK("mem5", 16'hF1F0, mem.store[5])
    `CHK("addr", 16'h0005, mem_addr)
    `CHK("flag", 1'b0, flag)
    `CHK("acc", 32'hCAFE0001, acc)
    `CHK("mask", 16'hFF00, mask)
  endtask
  task t_round;
    mem.store[7] = 16'h3F01;
    load_regs(32'h0077FFFF, 32'h0, 32'h0, 16'h0);
    run_op(xmr_pkg::OP_RND_LOAD, 16'h0007, 16'h0000);
    `CHK("acc", 32'h3F018000, acc)
    `CHK("lat", 3, lat)
  endtask
  task t_clr_buf;
    load_regs(32'hFFFF0000, 32'h0F0F0F0F, 32'h3F011111, 16'h00A5);
    // with the enable low neither the pending op nor the loads may act
    @(posedge clk);
    ce    <= 1'b0;
    valid <= 1'b1;
    op    <= xmr_pkg::OP_CLR_PROD;
    acc_d <= 32'h0;
    wr    <= 4'hF;
    repeat (3) @(posedge clk);
    `CHK("prodfrz", 32'h3F011111, prod)
    `CHK("accfrz", 32'hFFFF0000, acc)
    `CHK("donefrz", 1'b0, done)
    ce    <= 1'b1;
    valid <= 1'b0;
    wr    <= 4'h0;
    run_op(xmr_pkg::OP_CLR_PROD, 16'h0000, 16'h0000);
    `CHK("prod", 32'h0, prod)
    `CHK("acc", 32'hFFFF0000, acc)
    `CHK("abuf", 32'h0F0F0F0F, abuf)
    `CHK("mask", 16'h00A5, mask)
    `CHK("rd", 1'b0, rd_seen)
    `CHK("lat", 1, lat)
    run_op(xmr_pkg::OP_XOR_BUF, 16'h0000, 16'h0000);
    `CHK("accx", 32'hF0F00F0F, acc)
    `CHK("abufx", 32'h0F0F0F0F, abuf)
    `CHK("latx", 1, lat)
    run_op(xmr_pkg::OP_XOR_BUF, 16'h0000, 16'h0000);
    `CHK("accx2", 32'hFFFF0000, acc)
  endtask
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_xor_imm();
    t_xor_mask();
    t_round();
    t_clr_buf();
    end_sim();
  end
endmodule
`default_nettype wire
